// file: rtl/dcp_regs.sv
// What this block does
// - page 01 steers to I, 10 to Q
// - page 11 resets; writes both, reads I
// - steering only in four paged ranges
// - bit 7 drives reference power-down, reset 0
// - bit 6 powers down I, reset 1
// - bit 4 powers down Q, reset 1
// - bit 2 master bias kills both channels
// - mask 1: Q down on pin fall, low
// - mask 0: I down on pin fall, low
`timescale 1ns/1ps
`default_nettype none
module dcp_regs
  import dcp_pkg::*;
#(
  parameter logic [7:0] PROD_LO = 8'h5A, // arbitrary value
  parameter logic [7:0] PROD_HI = 8'hC3, // arbitrary value
  parameter logic [3:0] GRADE = 4'h1, // arbitrary value
  parameter logic [3:0] REV = 4'h7 // arbitrary value
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // serial port
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  // transmit gate pins
  input wire logic tx_gate_pin_ch0_i,
  input wire logic tx_gate_pin_ch1_i,
  // power controls
  output logic reference_powerdown_o,
  output logic master_bias_powerdown_o,
  output logic i_channel_off_o,
  output logic q_channel_off_o,
  // per-channel protect fields
  output logic [7:0] prot_ch0_o,
  output logic [7:0] prot_ch1_o,
  // paged registers held outside this bank
  output logic [11:0] ext_addr_o,
  output logic [7:0] ext_wdata_o,
  output logic [1:0] ext_wr_o,
  input wire logic [7:0] ext_rdata_ch0_i,
  input wire logic [7:0] ext_rdata_ch1_i
);
  // ***************************************************
  // input synchronisers
  // ***************************************************
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] filt;
  logic [NSYNC-1:0] filt_d;
  assign pin_raw = {tx_gate_pin_ch1_i, tx_gate_pin_ch0_i,
                    spi_sdi_i, spi_cs_n_i, spi_sclk_i};
  // a change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
          sync3[gi] <= 1'b1;
          filt[gi] <= 1'b1;
          filt_d[gi] <= 1'b1;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            filt[gi] <= sync3[gi];
          end
          filt_d[gi] <= filt[gi];
        end
      end
    end
  endgenerate
  logic sclk_rise;
  logic sclk_fall;
  logic cs_on;
  logic sdi;
  logic [1:0] tx_pin;
  logic [1:0] tx_fall;
  assign sclk_rise = filt[0] & ~filt_d[0];
  assign sclk_fall = ~filt[0] & filt_d[0];
  assign cs_on = ~filt[1];
  assign sdi = filt[2];
  assign tx_pin = filt[4:3];
  assign tx_fall = ~filt[4:3] & filt_d[4:3];
  // ***************************************************
  // serial frame engine
  // ***************************************************
  dcp_state_t state;
  logic [4:0] cnt;
  logic [14:0] ish;
  logic [6:0] dsh;
  logic rd_op;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic wr_stb;
  logic rd_load;
  logic rd_load_d;
  // one byte per frame; extra clocks after it are ignored
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !cs_on) begin
      state <= DCP_IDLE;
      cnt <= 5'h00;
      ish <= 15'h0000;
      dsh <= 7'h00;
      rd_op <= 1'b0;
      wr_stb <= 1'b0;
      rd_load <= 1'b0;
      rd_load_d <= 1'b0;
      if (srst_i) begin // address and data outlive the frame for the ext ports
        addr <= 12'h000;
        wdata <= 8'h00;
      end
    end else begin
      wr_stb <= 1'b0;
      rd_load <= 1'b0;
      rd_load_d <= rd_load;
      case (state)
        DCP_IDLE: begin
          state <= DCP_INSTR;
        end
        DCP_INSTR: begin
          if (sclk_rise) begin
            ish <= {ish[13:0], sdi};
            cnt <= cnt + 5'h01;
            if (cnt == INSTR_LAST) begin
              state <= DCP_DATA;
              cnt <= 5'h00;
              rd_op <= ish[14];
              addr <= {ish[10:0], sdi};
              rd_load <= ish[14];
            end
          end
        end
        DCP_DATA: begin
          if (sclk_rise) begin
            dsh <= {dsh[5:0], sdi};
            cnt <= cnt + 5'h01;
            if (cnt == DATA_LAST) begin
              state <= DCP_DONE;
              wdata <= {dsh, sdi};
              wr_stb <= ~rd_op;
            end
          end
        end
        default: begin
          state <= DCP_DONE;
        end
      endcase
    end
  end
  // ***************************************************
  // address decode
  // ***************************************************
  logic paged;
  logic [1:0] ch_sel;
  logic [1:0] page;
  assign paged = (addr >= PG0_LO && addr <= PG0_HI) ||
                 (addr >= PG1_LO && addr <= PG1_HI) ||
                 (addr >= PG2_LO && addr <= PG2_HI) ||
                 (addr >= PG3_LO && addr <= PG3_HI);
  // page codes double as channel enables; 00 selects neither, so writes go nowhere
  assign ch_sel = page;
  // ***************************************************
  // registers
  // ***************************************************
  logic [7:0] pwr;
  logic [1:0] mask;
  // page select, only the low two bits are stored
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      page <= PAGE_RST;
    end else if (wr_stb && addr == ADDR_PAGE) begin
      page <= wdata[1:0];
    end
  end
  // main power control, reserved bits stay zero
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pwr <= PWR_RST;
    end else if (wr_stb && addr == ADDR_PWR) begin
      pwr <= wdata & PWR_WMASK;
    end
  end
  // transmit gate mask
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mask <= MASK_RST;
    end else if (wr_stb && addr == ADDR_MASK) begin
      mask <= wdata[1:0];
    end
  end
  // paged protect copies, one per channel
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prot_ch0_o <= PROT_RST;
      prot_ch1_o <= PROT_RST;
    end else if (wr_stb && addr == ADDR_PROT) begin
      if (ch_sel[0]) begin
        prot_ch0_o <= wdata & PROT_WMASK;
      end
      if (ch_sel[1]) begin
        prot_ch1_o <= wdata & PROT_WMASK;
      end
    end
  end
  // paged registers outside the bank get a per-channel strobe
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ext_addr_o <= 12'h000;
      ext_wdata_o <= 8'h00;
      ext_wr_o <= 2'b00;
    end else begin
      ext_addr_o <= addr;
      ext_wdata_o <= wdata;
      if (wr_stb && paged && addr != ADDR_PROT) begin
        ext_wr_o <= ch_sel;
      end else begin
        ext_wr_o <= 2'b00;
      end
    end
  end
  // ***************************************************
  // read path
  // ***************************************************
  logic [7:0] rdata;
  logic [7:0] rd_sh;
  // reads of a paged address come from Q only on page 10
  always_comb begin
    if (addr == ADDR_PROD_LO) begin
      rdata = PROD_LO;
    end else if (addr == ADDR_PROD_HI) begin
      rdata = PROD_HI;
    end else if (addr == ADDR_GRADE) begin
      rdata = {GRADE, REV};
    end else if (addr == ADDR_PAGE) begin
      rdata = {6'h00, page};
    end else if (addr == ADDR_PWR) begin
      rdata = pwr;
    end else if (addr == ADDR_MASK) begin
      rdata = {6'h00, mask};
    end else if (addr == ADDR_PROT) begin
      rdata = (page == PAGE_Q) ? prot_ch1_o : prot_ch0_o;
    end else if (paged && page != 2'b00) begin
      rdata = (page == PAGE_Q) ? ext_rdata_ch1_i : ext_rdata_ch0_i;
    end else begin
      rdata = 8'h00;
    end
  end
  // data leaves msb first, changed on falling sclk edges
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !cs_on) begin
      rd_sh <= 8'h00;
      spi_sdo_o <= 1'b0;
      spi_sdo_oe_o <= 1'b0;
    end else if (rd_load_d) begin // one cycle late so ext ports already show the address
      rd_sh <= rdata;
    end else if (sclk_fall && state == DCP_DATA && rd_op) begin
      spi_sdo_oe_o <= 1'b1;
      spi_sdo_o <= rd_sh[7];
      rd_sh <= {rd_sh[6:0], 1'b0};
    end
  end
  // ***************************************************
  // power outputs
  // ***************************************************
  logic [1:0] gated;
  // held down from the pin's falling edge until it rises
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      gated <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (mask[c] && tx_fall[c]) begin
          gated[c] <= 1'b1;
        end else if (!mask[c] || tx_pin[c]) begin
          gated[c] <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reference_powerdown_o <= 1'b0;
      master_bias_powerdown_o <= 1'b1;
      i_channel_off_o <= 1'b1;
      q_channel_off_o <= 1'b1;
    end else begin
      reference_powerdown_o <= pwr[PWR_REF_BIT];
      master_bias_powerdown_o <= pwr[PWR_M_BIT];
      i_channel_off_o <= pwr[PWR_I_BIT] | pwr[PWR_M_BIT] | gated[0];
      q_channel_off_o <= pwr[PWR_Q_BIT] | pwr[PWR_M_BIT] | gated[1];
    end
  end
  // ***************************************************
  // assertions
  // ***************************************************
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_prot_wr(logic [1:0] pg); wr_stb && addr == ADDR_PROT && page == pg; endsequence
  property p_page_i; s_prot_wr(PAGE_I) |=>
    prot_ch0_o == ($past(wdata) & PROT_WMASK) && $stable(prot_ch1_o); endproperty
  a_page_i: assert property (p_page_i) else $error("page 01 write misrouted");
  property p_page_both; s_prot_wr(PAGE_BOTH) |=> prot_ch0_o == prot_ch1_o; endproperty
  a_page_both: assert property (p_page_both) else $error("page 11 write not both");
  property p_unpaged; wr_stb && !paged |=> ext_wr_o == 2'b00; endproperty
  a_unpaged: assert property (p_unpaged) else $error("unpaged write strobed");
  sequence s_pwr_wr; wr_stb && addr == ADDR_PWR; endsequence
  property p_ref; s_pwr_wr ##1 1'b1 |=> reference_powerdown_o == $past(wdata[7], 2); endproperty
  a_ref: assert property (p_ref) else $error("reference power-down wrong");
  property p_i_pd; pwr[PWR_I_BIT] |=> i_channel_off_o; endproperty
  a_i_pd: assert property (p_i_pd) else $error("I channel not down");
  property p_q_pd; pwr[PWR_Q_BIT] |=> q_channel_off_o; endproperty
  a_q_pd: assert property (p_q_pd) else $error("Q channel not down");
  property p_master; pwr[PWR_M_BIT] |=>
    i_channel_off_o && q_channel_off_o && master_bias_powerdown_o; endproperty
  a_master: assert property (p_master) else $error("master bias not obeyed");
  sequence s_gate(int c); mask[c] && tx_fall[c]; endsequence
  property p_gate_q; s_gate(1) |=> gated[1] ##1 q_channel_off_o; endproperty
  a_gate_q: assert property (p_gate_q) else $error("Q not gated off");
  property p_gate_i; s_gate(0) |=> gated[0] ##1 i_channel_off_o; endproperty
  a_gate_i: assert property (p_gate_i) else $error("I not gated off");
  property p_id; rd_load_d && addr == ADDR_PROD_LO |=> rd_sh == PROD_LO; endproperty
  a_id: assert property (p_id) else $error("identity read wrong");
  property p_rsvd; rd_load_d && addr == ADDR_MASK |=> rd_sh[7:2] == 6'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
endmodule
`default_nettype wire

// file: shared/dcp_pkg.sv
`default_nettype none
package dcp_pkg;
  // ***************************************************
  // register offsets
  // ***************************************************
  localparam logic [11:0] ADDR_PROD_LO = 12'h004;
  localparam logic [11:0] ADDR_PROD_HI = 12'h005;
  localparam logic [11:0] ADDR_GRADE = 12'h006;
  localparam logic [11:0] ADDR_PAGE = 12'h008;
  localparam logic [11:0] ADDR_PWR = 12'h011;
  localparam logic [11:0] ADDR_MASK = 12'h012;
  localparam logic [11:0] ADDR_PROT = 12'h013;
  // paged address ranges, low and high bound each
  localparam logic [11:0] PG0_LO = 12'h013;
  localparam logic [11:0] PG0_HI = 12'h014;
  localparam logic [11:0] PG1_LO = 12'h034;
  localparam logic [11:0] PG1_HI = 12'h03D;
  localparam logic [11:0] PG2_LO = 12'h110;
  localparam logic [11:0] PG2_HI = 12'h124;
  localparam logic [11:0] PG3_LO = 12'h135;
  localparam logic [11:0] PG3_HI = 12'h14C;
  // ***************************************************
  // fields and reset values
  // ***************************************************
  localparam int PWR_REF_BIT = 7;
  localparam int PWR_I_BIT = 6;
  localparam int PWR_Q_BIT = 4;
  localparam int PWR_M_BIT = 2;
  localparam logic [7:0] PWR_WMASK = 8'hD4;
  localparam logic [7:0] PWR_RST = 8'h54;
  localparam logic [7:0] PROT_WMASK = 8'h2C;
  localparam logic [7:0] PROT_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] PAGE_RST = 2'h3;
  localparam logic [1:0] PAGE_I = 2'h1;
  localparam logic [1:0] PAGE_Q = 2'h2;
  localparam logic [1:0] PAGE_BOTH = 2'h3;
  // ***************************************************
  // serial frame
  // ***************************************************
  localparam logic [4:0] INSTR_LAST = 5'h0F;
  localparam logic [4:0] DATA_LAST = 5'h07;
  typedef enum logic [1:0] {
    DCP_IDLE = 2'b00,
    DCP_INSTR = 2'b01,
    DCP_DATA = 2'b10,
    DCP_DONE = 2'b11
  } dcp_state_t;
endpackage
`default_nettype wire

// file: dv/dcp_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************
// serial host model
// ****************************
module dcp_host (
  // clock
  input wire logic clk_i,
  // serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  // each sclk phase stays well above the 2-cycle pin filter minimum
  localparam int HALF = 6;
  // idle: sclk parked low, chip select off
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // one frame: 16 instruction bits then 8 data bits, msb first
  task automatic xfer(input logic rd, input logic [11:0] addr, input logic [7:0] wd,
                      output logic [7:0] rdat);
    logic [23:0] sh;
    sh = {rd, 3'h0, addr, wd};
    rdat = 8'h00;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi_o <= sh[i];
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b1;
      if (i < 8) rdat[i] = sdo_i; // sdo has settled since the previous fall
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (HALF) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o; // released line never shows a stale bit
    repeat (8) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
  import dcp_pkg::*;
  localparam logic [7:0] ID_LO = 8'h3C; // arbitrary value
  localparam logic [7:0] ID_HI = 8'h7E; // arbitrary value
  localparam logic [3:0] ID_GR = 4'h9; // arbitrary value
  localparam logic [3:0] ID_RV = 4'h5; // arbitrary value
  logic sys_clk_i, srst_i, sclk, cs_n, sdi, sdo, sdo_oe, tx0, tx1;
  logic ref_pd, mb_pd, i_off, q_off;
  logic [7:0] prot0, prot1, ext_wdata, rd0, rd1, rdat;
  logic [11:0] ext_addr;
  logic [1:0] ext_wr, wr_seen;
  logic oe_seen;
  int fail_count, checked, cycles;
  // ****************************
  // design and host
  // ****************************
  dcp_regs #(.PROD_LO(ID_LO), .PROD_HI(ID_HI), .GRADE(ID_GR), .REV(ID_RV)) u_dcp_regs (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
    .tx_gate_pin_ch0_i(tx0), .tx_gate_pin_ch1_i(tx1),
    .reference_powerdown_o(ref_pd), .master_bias_powerdown_o(mb_pd),
    .i_channel_off_o(i_off), .q_channel_off_o(q_off),
    .prot_ch0_o(prot0), .prot_ch1_o(prot1), .ext_addr_o(ext_addr),
    .ext_wdata_o(ext_wdata), .ext_wr_o(ext_wr),
    .ext_rdata_ch0_i(rd0), .ext_rdata_ch1_i(rd1));
  dcp_host u_dcp_host (.clk_i(sys_clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
    .sdo_i(sdo));
  // clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // collect write pulses, which last one cycle only
  always @(posedge sys_clk_i) begin
    if (ext_wr !== 2'h0) wr_seen <= wr_seen | ext_wr;
  end
  // remember whether sdo was ever driven since the last clear
  always @(posedge sys_clk_i) begin
    if (sdo_oe === 1'b1) oe_seen <= 1'b1;
  end
  // hang guard: well above the roughly 30400 cycles the tests take
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      fail_count++;
      stop_test();
    end
  end
  // ****************************
  // access tasks
  // ****************************
  task automatic rd(input logic [11:0] a);
    u_dcp_host.xfer(1'b1, a, 8'h00, rdat);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] junk;
    u_dcp_host.xfer(1'b0, a, d, junk);
  endtask
  // pins move together, then the filter gets time to settle
  task automatic gate(input logic a, input logic b);
    @(posedge sys_clk_i);
    tx0 <= a;
    tx1 <= b;
    repeat (10) @(posedge sys_clk_i);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************
  // scenarios
  // ****************************
  task automatic t_reset();
    `CHK(({ref_pd, mb_pd, i_off, q_off}), 4'h7)
    wr(12'h0FF, 8'hFF);
    `CHK(oe_seen, 1'b0)
    rd(ADDR_PWR);
    `CHK(rdat, 8'h54)
    `CHK(oe_seen, 1'b1)
    `CHK(sdo_oe, 1'b0)
    rd(ADDR_MASK);
    `CHK(rdat, 8'h00)
    rd(ADDR_PAGE);
    `CHK(rdat, 8'h03)
    rd(12'h0FF);
    `CHK(rdat, 8'h00)
    $display("test reset done");
  endtask
  // identity registers ignore an inverted write
  task automatic t_ident();
    logic [11:0] a [3] = '{ADDR_PROD_LO, ADDR_PROD_HI, ADDR_GRADE};
    logic [7:0] e [3] = '{ID_LO, ID_HI, {ID_GR, ID_RV}};
    for (int k = 0; k < 3; k++) begin
      wr(a[k], ~e[k]);
      rd(a[k]);
      `CHK(rdat, e[k])
    end
    $display("test ident done");
  endtask
  // last entry leaves every converter powered with reserved bits written 1
  task automatic t_power();
    logic [7:0] v [7] = '{8'hFF, 8'h00, 8'h04, 8'h40, 8'h10, 8'h80, 8'h2B};
    for (int k = 0; k < 7; k++) begin
      wr(ADDR_PWR, v[k]);
      rd(ADDR_PWR);
      `CHK(rdat, v[k] & 8'hD4)
      `CHK(ref_pd, v[k][7])
      `CHK(mb_pd, v[k][2])
      `CHK(i_off, v[k][6] | v[k][2])
      `CHK(q_off, v[k][4] | v[k][2])
    end
    $display("test power done");
  endtask
  task automatic t_page();
    wr(ADDR_PROT, 8'hFF);
    `CHK(({prot0, prot1}), 16'h2C2C)
    wr(ADDR_PAGE, 8'hFD);
    rd(ADDR_PAGE);
    `CHK(rdat, 8'h01)
    wr(ADDR_PROT, 8'h04);
    `CHK(({prot0, prot1}), 16'h042C)
    wr(ADDR_PAGE, 8'h02);
    wr(ADDR_PROT, 8'h08);
    `CHK(({prot0, prot1}), 16'h0408)
    rd(ADDR_PROT);
    `CHK(rdat, 8'h08)
    rd(12'h034);
    `CHK(rdat, rd1)
    wr(ADDR_PAGE, 8'h03);
    rd(ADDR_PROT);
    `CHK(rdat, 8'h04)
    rd(12'h14C);
    `CHK(rdat, rd0)
    $display("test page done");
  endtask
  // range edges: first seven inside the paged ranges, the rest just outside;
  // page 00 must strobe neither channel
  task automatic t_steer();
    logic [11:0] a [14] = '{12'h014, 12'h034, 12'h03D, 12'h110, 12'h124, 12'h135, 12'h14C,
      12'h015, 12'h033, 12'h03E, 12'h10F, 12'h125, 12'h134, 12'h14D};
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_PAGE, 8'(p));
      for (int k = 0; k < 14; k++) begin
        wr_seen <= 2'h0;
        wr(a[k], 8'h96);
        `CHK(wr_seen, (k < 7) ? 2'(p) : 2'h0)
      end
    end
    `CHK(ext_addr, 12'h14D)
    `CHK(ext_wdata, 8'h96)
    $display("test steer done");
  endtask
  task automatic t_gate();
    wr(ADDR_MASK, 8'hFF);
    rd(ADDR_MASK);
    `CHK(rdat, 8'h03)
    gate(1'b0, 1'b1);
    `CHK(({i_off, q_off}), 2'b10)
    gate(1'b1, 1'b0);
    `CHK(({i_off, q_off}), 2'b01)
    wr(ADDR_MASK, 8'h01);
    `CHK(({i_off, q_off}), 2'b00)
    gate(1'b0, 1'b1);
    `CHK(({i_off, q_off}), 2'b10)
    wr(ADDR_MASK, 8'h00);
    gate(1'b1, 1'b1);
    gate(1'b0, 1'b0);
    `CHK(({i_off, q_off}), 2'b00)
    $display("test gate done");
  endtask
  // ****************************
  // main sequence
  // ****************************
  initial begin
    srst_i = 1'b1;
    tx0 = 1'b1;
    tx1 = 1'b1;
    rd0 = 8'hA5;
    rd1 = 8'h5B;
    wr_seen = 2'h0;
    oe_seen = 1'b0;
    fail_count = 0;
    checked = 0;
    cycles = 0;
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    t_reset();
    t_ident();
    t_power();
    t_page();
    t_steer();
    t_gate();
    stop_test();
  end
endmodule
`default_nettype wire
